/* File: logic/lpsd_pkg.sv */
// package: command codes, mode register layout and geometry for the sdram core
package lpsd_pkg;
  localparam int BANK_W     = 2;
  localparam int ROW_W      = 11;
  localparam int COL_W      = 8;
  localparam int ADDR_W     = 11;
  localparam int DATA_W     = 32;
  localparam int MASK_W     = 4;
  localparam int NUM_ROWS   = 2048;
  localparam int NUM_COLS   = 256;
  localparam int MODE_W     = 13;
  // mode register field positions
  localparam int BL_LSB     = 0;
  localparam int BT_BIT     = 3;
  localparam int RL_LSB     = 4;
  localparam int OPM_LSB    = 7;
  localparam int WB_BIT     = 9;
  localparam int AP_BIT     = 10;
  // burst length and read latency codes
  localparam logic [2:0] BL_1    = 3'h0;
  localparam logic [2:0] BL_2    = 3'h1;
  localparam logic [2:0] BL_4    = 3'h2;
  localparam logic [2:0] BL_8    = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
  localparam logic [2:0] RL_2    = 3'h2;
  localparam logic [2:0] RL_3    = 3'h3;
  // register-load targets on bank_sel
  localparam logic [1:0] SEL_BASE = 2'h0;
  localparam logic [1:0] SEL_EXT  = 2'h2;
  localparam logic [MODE_W-1:0] MODE_RESET = 13'h0021; // bl 2, latency 2
  localparam logic [10:0]       EXT_RESET  = 11'h000;

  // command word {ras_n, cas_n, we_n}
  typedef enum logic [2:0] {
    LPSD_CMD_LOAD  = 3'h0,
    LPSD_CMD_REF   = 3'h1,
    LPSD_CMD_PRE   = 3'h2,
    LPSD_CMD_ACT   = 3'h3,
    LPSD_CMD_WRITE = 3'h4,
    LPSD_CMD_READ  = 3'h5,
    LPSD_CMD_STOP  = 3'h6,
    LPSD_CMD_NOP   = 3'h7
  } lpsd_cmd_e;

  typedef struct packed {
    logic              cs_n;
    lpsd_cmd_e         cmd;
    logic [BANK_W-1:0] bank_sel;
    logic [ADDR_W-1:0] addr_lines;
  } lpsd_cmd_s;

  typedef struct packed {
    logic       write_burst_bit;
    logic [1:0] op_mode;
    logic [2:0] read_latency_field;
    logic       burst_order_bit;
    logic [2:0] burst_len_field;
  } lpsd_mode_s;

  // column visited at a burst index
  function automatic logic [COL_W-1:0] lpsd_burst_col(
    input logic [COL_W-1:0] start,
    input logic [COL_W-1:0] idx,
    input logic [2:0]       blen,
    input logic             order
  );
    logic [COL_W-1:0] msk;
    logic [COL_W-1:0] low;
    msk = 8'h00;
    case (blen)
      BL_2:    msk = 8'h01;
      BL_4:    msk = 8'h03;
      BL_8:    msk = 8'h07;
      BL_PAGE: msk = 8'hff;
      default: msk = 8'h00;
    endcase
    if (order && blen != BL_PAGE)
      low = start ^ idx;
    else
      low = start + idx;
    return (start & ~msk) | (low & msk);
  endfunction

  // beats in a burst, 0 for a reserved code
  function automatic logic [8:0] lpsd_burst_beats(input logic [2:0] blen);
    case (blen)
      BL_1:    return 9'h001;
      BL_2:    return 9'h002;
      BL_4:    return 9'h004;
      BL_8:    return 9'h008;
      BL_PAGE: return 9'h100;
      default: return 9'h000;
    endcase
  endfunction
endpackage

/* File: logic/lpsd_bank_store.sv */
// bank array: four banks of rows by columns, byte-masked write, registered read
`timescale 1ns/1ns
`default_nettype none
module lpsd_bank_store
  import lpsd_pkg::*;
#(
  parameter int NROWS = NUM_ROWS
)(
  // clock
  input  wire logic                clock,
  input  wire logic                ce,
  // write port
  input  wire logic                wr_en,
  input  wire logic [MASK_W-1:0]   wr_mask,
  input  wire logic [BANK_W-1:0]   wr_bank,
  input  wire logic [ROW_W-1:0]    wr_row,
  input  wire logic [COL_W-1:0]    wr_col,
  input  wire logic [DATA_W-1:0]   wr_data,
  // read port
  input  wire logic [BANK_W-1:0]   rd_bank,
  input  wire logic [ROW_W-1:0]    rd_row,
  input  wire logic [COL_W-1:0]    rd_col,
  output logic      [DATA_W-1:0]   rd_data
);
  localparam int DEPTH = 4 * NROWS * NUM_COLS;
  logic [DATA_W-1:0] mem [DEPTH];

  function automatic int unsigned lin(input logic [BANK_W-1:0] b,
                                      input logic [ROW_W-1:0] r,
                                      input logic [COL_W-1:0] c);
    return ((int'(b) * NROWS + (int'(r) % NROWS)) * NUM_COLS) + int'(c);
  endfunction

  always_ff @(posedge clock)
  begin
    if (ce)
    begin
      for (int i = 0; i < MASK_W; i++)
        if (wr_en && !wr_mask[i])
          mem[lin(wr_bank, wr_row, wr_col)][i*8 +: 8] <= wr_data[i*8 +: 8];
      rd_data <= mem[lin(rd_bank, rd_row, rd_col)];
    end
  end
endmodule // lpsd_bank_store
`default_nettype wire

/* File: logic/lpsd_core.sv */
// command front end: pin decode, mode register, burst sequencing, data path
`timescale 1ns/1ns
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - all inputs sampled on rising clock
// - clock enable low freezes internal state
// - deselect ignores all but clock, enable, mask
// - byte mask blanks reads, blocks writes
// - 11-bit row, 8-bit column, line 10 autoprecharge
// - four banks, 2048 rows, 256 columns, 32 bits
// - activate opens row; read/write gives column
// - mode loaded, then extended, before operation
// - mode register holds until reloaded
// - mode fields: length, type, latency, op, write
// - bank lines pick base or extended register
// - length codes 1,2,4,8, full page
// - bit 3 picks sequential or interleaved
// - read latency two or three only
// - bit 9 makes writes single location
// - burst wraps within its aligned block
// - sequential adds index, interleaved xors
// - full page walks whole row, sequential
// - length one: one column, order ignored
// - read data valid latency edges after command
// - write mask now, read mask two later
// - load opcode on address lines 0-10
module lpsd_core
  import lpsd_pkg::*;
#(
  parameter int NROWS = NUM_ROWS
)(
  // clock, reset and enable
  input  wire logic                clock,
  input  wire logic                rstn,
  input  wire logic                cke,
  // command pins
  input  wire logic                cs_n,
  input  wire logic                ras_n,
  input  wire logic                cas_n,
  input  wire logic                we_n,
  input  wire logic [BANK_W-1:0]   bank_sel,
  input  wire logic [ADDR_W-1:0]   addr_lines,
  input  wire logic [MASK_W-1:0]   byte_mask_lines,
  // data pins
  input  wire logic [DATA_W-1:0]   data_lines_in,
  output logic      [DATA_W-1:0]   data_lines_out,
  output logic      [MASK_W-1:0]   data_lines_oe,
  // status
  output logic      [MODE_W-1:0]   mode_value,
  output logic      [10:0]         ext_mode_value
);
  //////////////////////////////////////////////////////////////////////////
  // pin decode; the device registers pins on the edge itself
  lpsd_cmd_s  pin;
  lpsd_mode_s mode;
  logic [MODE_W-1:0] mode_reg;
  logic [10:0]       ext_reg;

  assign pin.cs_n       = cs_n;
  assign pin.cmd        = lpsd_cmd_e'({ras_n, cas_n, we_n});
  assign pin.bank_sel   = bank_sel;
  assign pin.addr_lines = addr_lines;
  assign mode           = lpsd_mode_s'(mode_reg[9:0]);

  wire run        = cke;
  wire selected   = run && !pin.cs_n;
  wire is_load    = selected && pin.cmd == LPSD_CMD_LOAD;
  wire load_base  = is_load && pin.bank_sel == SEL_BASE;
  wire load_ext   = is_load && pin.bank_sel == SEL_EXT;
  wire is_act     = selected && pin.cmd == LPSD_CMD_ACT;
  wire is_read    = selected && pin.cmd == LPSD_CMD_READ;
  wire is_write   = selected && pin.cmd == LPSD_CMD_WRITE;
  wire is_pre     = selected && pin.cmd == LPSD_CMD_PRE;
  wire is_stop    = selected && pin.cmd == LPSD_CMD_STOP;

  //////////////////////////////////////////////////////////////////////////
  // mode registers: undefined at power-up, so a reset value stands in
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      mode_reg <= MODE_RESET;
      ext_reg  <= EXT_RESET;
    end
    else
    begin
      if (load_base)
        mode_reg <= {2'h0, pin.addr_lines};
      if (load_ext)
        ext_reg <= pin.addr_lines;
    end
  end
  assign mode_value     = mode_reg;
  assign ext_mode_value = ext_reg;

  //////////////////////////////////////////////////////////////////////////
  // open rows per bank
  logic [ROW_W-1:0] open_row [4];
  logic [3:0]       row_open;

  //////////////////////////////////////////////////////////////////////////
  // burst sequencer
  typedef enum logic [1:0] {
    LPSD_IDLE  = 2'h0,
    LPSD_RBURST = 2'h1,
    LPSD_WBURST = 2'h2
  } lpsd_state_e;

  lpsd_state_e      state;
  logic [COL_W-1:0] start_col;
  logic [BANK_W-1:0] burst_bank;
  logic [8:0]       beat;
  logic [8:0]       beats;
  logic             autopre;

  wire [2:0]  blen     = mode.burst_len_field;
  wire [8:0]  rd_beats = lpsd_burst_beats(blen);
  wire [8:0]  wr_beats = mode.write_burst_bit ? 9'h001 : rd_beats;
  wire        bl_ok    = rd_beats != 9'h000 && !(blen == BL_PAGE && mode.burst_order_bit);
  wire [COL_W-1:0] cur_col = lpsd_burst_col(start_col, beat[COL_W-1:0], blen,
                                            mode.burst_order_bit);
  wire        new_col   = (is_read || is_write) && bl_ok && row_open[pin.bank_sel];
  // autoprecharge: row closes once the burst runs out or is stopped
  wire        auto_close = run && !new_col && autopre && state != LPSD_IDLE &&
                           (is_stop || beat >= beats);

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      state      <= LPSD_IDLE;
      beat       <= 9'h000;
      beats      <= 9'h000;
      start_col  <= 8'h00;
      burst_bank <= 2'h0;
      autopre    <= 1'b0;
    end
    else if (run)
    begin
      if (new_col)
      begin
        state      <= is_read ? LPSD_RBURST : LPSD_WBURST;
        start_col  <= pin.addr_lines[COL_W-1:0];
        burst_bank <= pin.bank_sel;
        beats      <= is_read ? rd_beats : wr_beats;
        autopre    <= pin.addr_lines[AP_BIT];
        beat       <= 9'h001;
      end
      else
      begin
        case (state)
          LPSD_IDLE: beat <= 9'h000;
          LPSD_RBURST, LPSD_WBURST:
          begin
            if (is_stop || beat >= beats)
              state <= LPSD_IDLE;
            // full page wraps around the row until stopped
            else if (blen == BL_PAGE && beat == 9'h0ff)
              beat <= 9'h000;
            else
              beat <= beat + 9'h001;
          end
          default: state <= LPSD_IDLE;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // row bookkeeping sits after the sequencer so autoprecharge can reach it
  always_ff @(posedge clock)
  begin
    if (!rstn)
      row_open <= 4'h0;
    else if (is_act)
    begin
      row_open[pin.bank_sel] <= 1'b1;
      open_row[pin.bank_sel] <= pin.addr_lines[ROW_W-1:0];
    end
    else if (is_pre)
      row_open <= pin.addr_lines[AP_BIT] ? 4'h0 : row_open & ~(4'h1 << pin.bank_sel);
    else if (auto_close)
      row_open[burst_bank] <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // write path: column of this edge, masked in the same cycle
  wire [COL_W-1:0] wcol  = new_col ? pin.addr_lines[COL_W-1:0] : cur_col;
  wire [BANK_W-1:0] wbank = new_col ? pin.bank_sel : burst_bank;
  wire wr_now = run && ((new_col && is_write) ||
                (!new_col && state == LPSD_WBURST && beat < beats && !is_stop));
  wire rd_now = run && ((new_col && is_read) ||
                (!new_col && state == LPSD_RBURST && beat < beats && !is_stop));
  wire [COL_W-1:0] rcol = new_col ? pin.addr_lines[COL_W-1:0] : cur_col;

  logic [DATA_W-1:0] array_q;

  lpsd_bank_store #(.NROWS(NROWS)) u_store (
    .clock   (clock),
    .ce      (run),
    .wr_en   (wr_now),
    .wr_mask (byte_mask_lines),
    .wr_bank (wbank),
    .wr_row  (open_row[wbank]),
    .wr_col  (wcol),
    .wr_data (data_lines_in),
    .rd_bank (wbank),
    .rd_row  (open_row[wbank]),
    .rd_col  (rcol),
    .rd_data (array_q)
  );

  //////////////////////////////////////////////////////////////////////////
  // read pipeline: array gives data one edge later, delay pads to latency
  logic [2:0]        rvalid_pipe;
  logic [DATA_W-1:0] rdata_d1;
  logic [MASK_W-1:0] mask_d1;
  logic [MASK_W-1:0] mask_d2;
  wire  lat3 = mode.read_latency_field == RL_3;
  wire  out_valid = lat3 ? rvalid_pipe[1] : rvalid_pipe[0];
  wire [DATA_W-1:0] out_data = lat3 ? rdata_d1 : array_q;

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      rvalid_pipe    <= 3'h0;
      mask_d1        <= 4'h0;
      mask_d2        <= 4'h0;
      rdata_d1       <= 32'h0;
      data_lines_out <= 32'h0;
      data_lines_oe  <= 4'h0;
    end
    else
    begin
      if (run)
      begin
        rvalid_pipe    <= {rvalid_pipe[1:0], rd_now};
        rdata_d1       <= array_q;
        mask_d1        <= byte_mask_lines;
        mask_d2        <= mask_d1;
        data_lines_out <= out_data;
        data_lines_oe  <= out_valid ? ~mask_d1 : 4'h0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  property p_rl2;
    @(posedge clock) disable iff (!rstn)
      (is_read && new_col && mode.read_latency_field == RL_2 && byte_mask_lines == 4'h0)
      ##1 (cke && byte_mask_lines == 4'h0 [*1]) ##0 cke |=> data_lines_oe == 4'hf;
  endproperty
  a_rl2: assert property (p_rl2) else $error("latency two read not driven");

  property p_rl3;
    @(posedge clock) disable iff (!rstn)
      (is_read && new_col && lat3 && cke) ##1 cke[*2] |-> ##1 (data_lines_oe == ~$past(mask_d1));
  endproperty
  a_rl3: assert property (p_rl3) else $error("latency three mask wrong");

  property p_mode_hold;
    @(posedge clock) disable iff (!rstn) !load_base |=> $stable(mode_reg);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode register changed");

  property p_mode_load;
    @(posedge clock) disable iff (!rstn) load_base |=> mode_reg[10:0] == $past(addr_lines);
  endproperty
  a_mode_load: assert property (p_mode_load) else $error("mode load lost");

  property p_desel;
    @(posedge clock) disable iff (!rstn)
      cs_n && !auto_close |=> $stable(row_open) && $stable(ext_reg);
  endproperty
  a_desel: assert property (p_desel) else $error("deselected command acted");

  property p_freeze;
    @(posedge clock) disable iff (!rstn) !cke |=> $stable(state) && $stable(beat);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled");

  property p_single_write;
    @(posedge clock) disable iff (!rstn)
      (is_write && new_col && mode.write_burst_bit) |=> beats == 9'h001;
  endproperty
  a_single_write: assert property (p_single_write) else $error("write not single");

  property p_no_oe_write;
    @(posedge clock) disable iff (!rstn)
      (state == LPSD_WBURST && rvalid_pipe == 3'h0) |=> data_lines_oe == 4'h0;
  endproperty
  a_no_oe_write: assert property (p_no_oe_write) else $error("drove during write");

  property p_wrap;
    @(posedge clock) disable iff (!rstn)
      (state != LPSD_IDLE && blen == BL_4) |-> (cur_col[7:2] == start_col[7:2]);
  endproperty
  a_wrap: assert property (p_wrap) else $error("burst left its block");

  c_read:  cover property (@(posedge clock) is_read && new_col);
  c_write: cover property (@(posedge clock) is_write && new_col);
  c_load:  cover property (@(posedge clock) load_base);
  c_stop:  cover property (@(posedge clock) state == LPSD_RBURST && is_stop);
  c_autopre: cover property (@(posedge clock) auto_close);
endmodule // lpsd_core
`default_nettype wire

/* File: sim/lpsd_ctrl_model.sv */
// memory controller model: power-up sequence and per-cycle command driver
`timescale 1ns/1ns
`default_nettype none
module lpsd_ctrl_model
  import lpsd_pkg::*;
#(
  parameter int WAIT_CYC = 20  // shortened stand-in for the power-up wait
)(
  // clock
  input  wire logic                clock,
  // command pins
  output logic                     cke,
  output logic                     cs_n,
  output logic                     ras_n,
  output logic                     cas_n,
  output logic                     we_n,
  output logic      [BANK_W-1:0]   bank_sel,
  output logic      [ADDR_W-1:0]   addr_lines,
  output logic      [MASK_W-1:0]   byte_mask_lines,
  // write data
  output logic      [DATA_W-1:0]   data_lines_in
);
  logic cke_nx;

  initial
  begin
    cke_nx = 1'b1;
    cke = cke_nx;
    // deselected idle until the first drive
    {cs_n, ras_n, cas_n, we_n} = {1'b1, LPSD_CMD_NOP};
    {bank_sel, addr_lines, byte_mask_lines} = 17'h00000;
    data_lines_in = 32'h0f0f0f0f;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic drive(input logic cs, input lpsd_cmd_e c, input logic [1:0] ba,
                       input logic [10:0] a, input logic [3:0] m, input logic wv,
                       input logic [31:0] d);
    @(negedge clock);
    cke = cke_nx;
    cs_n = cs;
    {ras_n, cas_n, we_n} = c;
    bank_sel = ba;
    addr_lines = a;
    byte_mask_lines = m;
    // released bus shows the inverse, so stale data never matches
    data_lines_in = wv ? d : ~data_lines_in;
  endtask

  task automatic nop(input int n);
    for (int i = 0; i < n; i++)
    begin
      drive(1'b0, LPSD_CMD_NOP, 2'h0, 11'h000, 4'h0, 1'b0, 32'h0);
    end
  endtask

  task automatic set_cke(input logic b);
    cke_nx = b;
  endtask

  task automatic init(input logic [10:0] op, input logic [10:0] ext);
    cke_nx = 1'b1;
    nop(WAIT_CYC);
    drive(1'b0, LPSD_CMD_PRE, 2'h0, 11'h400, 4'h0, 1'b0, 32'h0);
    nop(2);
    repeat (2)
    begin
      drive(1'b0, LPSD_CMD_REF, 2'h0, 11'h000, 4'h0, 1'b0, 32'h0);
      nop(3);
    end
    drive(1'b0, LPSD_CMD_LOAD, SEL_BASE, op, 4'h0, 1'b0, 32'h0);
    nop(2);
    drive(1'b0, LPSD_CMD_LOAD, SEL_EXT, ext, 4'h0, 1'b0, 32'h0);
    nop(2);
  endtask
endmodule // lpsd_ctrl_model
`default_nettype wire

/* File: sim/tb_top.sv */
// testbench: controller model drives the core, reads checked against a column image
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import lpsd_pkg::*;
;
  logic                clock;
  logic                rstn;
  logic                cke;
  logic                cs_n;
  logic                ras_n;
  logic                cas_n;
  logic                we_n;
  logic [BANK_W-1:0]   bank_sel;
  logic [ADDR_W-1:0]   addr_lines;
  logic [MASK_W-1:0]   byte_mask_lines;
  logic [DATA_W-1:0]   data_lines_in;
  logic [DATA_W-1:0]   data_lines_out;
  logic [MASK_W-1:0]   data_lines_oe;
  logic [MODE_W-1:0]   mode_value;
  logic [10:0]         ext_mode_value;
  logic [31:0]         mem [256];
  int                  num_errors;
  int                  checked;
  int                  cyc;
  logic [2:0]          t_bl  [7] = '{3'h0, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h7};
  logic                t_bt  [7] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  logic [2:0]          t_lat [7] = '{3'h2, 3'h3, 3'h2, 3'h3, 3'h2, 3'h3, 3'h3};
  logic [7:0]          t_st  [7] = '{8'h35, 8'h11, 8'h02, 8'h05, 8'h1b, 8'h2e, 8'hfd};

  lpsd_core #(.NROWS(4)) uut (
    .clock(clock), .rstn(rstn), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .bank_sel(bank_sel), .addr_lines(addr_lines),
    .byte_mask_lines(byte_mask_lines), .data_lines_in(data_lines_in),
    .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe),
    .mode_value(mode_value), .ext_mode_value(ext_mode_value));

  lpsd_ctrl_model #(.WAIT_CYC(20)) ctl (
    .clock(clock), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .bank_sel(bank_sel), .addr_lines(addr_lines), .byte_mask_lines(byte_mask_lines),
    .data_lines_in(data_lines_in));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // hang guard: whole run is well under a thousand cycles
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      finish_test;
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic int beats(input logic [2:0] bl);
    case (bl)
      3'h0: return 1;
      3'h1: return 2;
      3'h2: return 4;
      3'h3: return 8;
      default: return 256;
    endcase
  endfunction

  function automatic logic [7:0] tcol(input logic [7:0] s, input logic [7:0] k,
                                      input logic [2:0] bl, input logic bt);
    logic [7:0] m;
    logic [7:0] lo;
    m = 8'(beats(bl) - 1);
    lo = (bt && bl != 3'h7) ? (s ^ k) : (s + k);
    return (s & ~m) | (lo & m);
  endfunction

  function automatic logic [10:0] mk(input logic [2:0] bl, input logic bt,
                                     input logic [2:0] lat, input logic wb);
    return {1'b0, wb, 2'b00, lat, bt, bl};
  endfunction

  task automatic ld(input logic [10:0] op);
    ctl.drive(1'b0, LPSD_CMD_LOAD, SEL_BASE, op, 4'h0, 1'b0, 32'h0);
    ctl.nop(2);
    chk("mode", {19'h0, mode_value}, {21'h0, op});
  endtask

  task automatic wr(input logic [7:0] st, input logic [2:0] bl, input logic bt,
                    input logic wb, input logic [3:0] m0, input logic [31:0] seed);
    int n;
    logic [7:0] c;
    logic [31:0] d;
    logic [3:0] m;
    n = wb ? 1 : beats(bl);
    for (int k = 0; k < n; k++)
    begin
      c = tcol(st, k[7:0], bl, bt);
      d = seed ^ {c, c, c, c};
      m = (k == 0) ? m0 : 4'h0;
      ctl.drive(1'b0, (k == 0) ? LPSD_CMD_WRITE : LPSD_CMD_NOP, 2'h1, {3'h0, st}, m, 1'b1, d);
      for (int b = 0; b < 4; b++)
        if (!m[b])
          mem[c][8*b +: 8] = d[8*b +: 8];
    end
    // a full-page write runs on until stopped
    ctl.drive(1'b0, (bl == 3'h7 && !wb) ? LPSD_CMD_STOP : LPSD_CMD_NOP, 2'h0, 11'h000, 4'h0,
              1'b0, 32'h0);
  endtask

  // mb: beat whose lanes mv blanks, 99 for none
  task automatic rd(input logic [7:0] st, input logic [2:0] bl, input logic bt,
                    input logic [2:0] lat, input int mb, input logic [3:0] mv);
    int n;
    logic [3:0] eo;
    logic [31:0] em;
    n = beats(bl);
    ctl.drive(1'b0, LPSD_CMD_READ, 2'h1, {3'h0, st}, 4'h0, 1'b0, 32'h0);
    // pins seen here are those the controller samples at edge j after the command;
    // a stop right after the last beat ends a full page and is harmless otherwise
    for (int j = 1; j <= lat + n; j++)
    begin
      ctl.drive(1'b0, (j == n) ? LPSD_CMD_STOP : LPSD_CMD_NOP, 2'h0, 11'h000,
                (j == lat + mb - 2) ? mv : 4'h0, 1'b0, 32'h0);
      if (j >= lat && j < lat + n)
      begin
        eo = (j - lat == mb) ? ~mv : 4'hf;
        em = {{8{eo[3]}}, {8{eo[2]}}, {8{eo[1]}}, {8{eo[0]}}};
        chk("oe", {28'h0, data_lines_oe}, {28'h0, eo});
        chk("rdata", data_lines_out & em,
            mem[tcol(st, 8'(j - lat), bl, bt)] & em);
      end
    end
    chk("oe_end", {28'h0, data_lines_oe}, 32'h0);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    num_errors = 0;
    checked = 0;
    cyc = 0;
    rstn = 1'b0;
    repeat (16) @(posedge clock);
    @(negedge clock);
    rstn = 1'b1;
    chk("mode_rst", {19'h0, mode_value}, {19'h0, MODE_RESET});
    chk("oe_rst", {28'h0, data_lines_oe}, 32'h0);
    ctl.init(mk(3'h7, 1'b0, 3'h2, 1'b0), 11'h015);
    chk("mode", {19'h0, mode_value}, {21'h0, mk(3'h7, 1'b0, 3'h2, 1'b0)});
    chk("ext", {21'h0, ext_mode_value}, 32'h015);
    $display("test init done");
    ctl.drive(1'b1, LPSD_CMD_LOAD, SEL_BASE, 11'h033, 4'h0, 1'b0, 32'h0);
    ctl.drive(1'b0, LPSD_CMD_LOAD, 2'h1, 11'h033, 4'h0, 1'b0, 32'h0);
    ctl.set_cke(1'b0);
    ctl.drive(1'b0, LPSD_CMD_LOAD, SEL_BASE, 11'h033, 4'h0, 1'b0, 32'h0);
    ctl.set_cke(1'b1);
    ctl.nop(2);
    chk("mode_kept", {19'h0, mode_value}, 32'h027);
    $display("test refused loads done");
    ctl.drive(1'b0, LPSD_CMD_ACT, 2'h1, 11'h003, 4'h0, 1'b0, 32'h0);
    ctl.nop(1);
    wr(8'h00, 3'h7, 1'b0, 1'b0, 4'h0, 32'ha53c0000);
    for (int i = 0; i < 7; i++)
    begin
      ld(mk(t_bl[i], t_bt[i], t_lat[i], 1'b0));
      rd(t_st[i], t_bl[i], t_bt[i], t_lat[i], 99, 4'h0);
    end
    $display("test burst orders done");
    ld(mk(3'h2, 1'b0, 3'h2, 1'b0));
    rd(8'h06, 3'h2, 1'b0, 3'h2, 2, 4'h6);
    ld(mk(3'h2, 1'b0, 3'h2, 1'b1));
    wr(8'h40, 3'h2, 1'b0, 1'b1, 4'h9, 32'h11112222);
    rd(8'h40, 3'h2, 1'b0, 3'h2, 99, 4'h0);
    $display("test masks and single write done");
    ld(mk(3'h3, 1'b1, 3'h3, 1'b0));
    wr(8'h8b, 3'h3, 1'b1, 1'b0, 4'h0, 32'h77770000);
    ld(mk(3'h3, 1'b0, 3'h2, 1'b0));
    rd(8'h88, 3'h3, 1'b0, 3'h2, 99, 4'h0);
    $display("test interleaved write done");
    ctl.drive(1'b0, LPSD_CMD_READ, 2'h1, 11'h488, 4'h0, 1'b0, 32'h0);
    ctl.nop(12);
    ctl.drive(1'b0, LPSD_CMD_READ, 2'h1, 11'h088, 4'h0, 1'b0, 32'h0);
    ctl.nop(4);
    chk("oe_closed", {28'h0, data_lines_oe}, 32'h0);
    $display("test autoprecharge done");
    finish_test;
  end
endmodule // tb_top
`default_nettype wire
